// ### common/ccs_pkg.sv
// constants for the can control, command and status block
// assumes an 8-bit cpu register port on one 40 MHz clock
package ccs_pkg;
    // register offsets
    localparam logic [7:0] OFS_CTRL    = 8'h20;
    localparam logic [7:0] OFS_CMD     = 8'h21;
    localparam logic [7:0] OFS_STAT    = 8'h22;
    localparam logic [7:0] OFS_IFLAG   = 8'h23;
    localparam logic [7:0] OFS_CFG_LO  = 8'h24;
    localparam logic [7:0] OFS_CFG_HI  = 8'h28;
    localparam logic [7:0] OFS_TXB_LO  = 8'h2A;
    localparam logic [7:0] OFS_TXB_HI  = 8'h33;
    // control field positions
    localparam int CTL_MODE = 7;
    localparam int CTL_SPD  = 6;
    localparam int CTL_OIE  = 4;
    localparam int CTL_EIE  = 3;
    localparam int CTL_TIE  = 2;
    localparam int CTL_RIE  = 1;
    localparam int CTL_RR   = 0;
    // command field positions
    localparam int CMD_RXA  = 7;
    localparam int CMD_RXB  = 6;
    localparam int CMD_CMP  = 5;
    localparam int CMD_SLP  = 4;
    localparam int CMD_COS  = 3;
    localparam int CMD_RRB  = 2;
    localparam int CMD_AT   = 1;
    localparam int CMD_TR   = 0;
    // interrupt flag positions
    localparam int IF_WAKE  = 4;
    localparam int IF_OVR   = 3;
    localparam int IF_ERR   = 2;
    localparam int IF_TX    = 1;
    localparam int IF_RX    = 0;
    // reset and read values
    localparam logic [7:0] CTRL_RST    = 8'h01;
    localparam logic [7:0] STAT_RST    = 8'h0C;
    localparam logic [7:0] CMD_READ    = 8'hFF;
    // counter limits
    localparam logic [8:0] WARN_LIMIT   = 9'h060;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
    localparam logic [7:0] RUNS_NORMAL  = 8'h01;
    localparam logic [7:0] RUNS_BUSOFF  = 8'h80;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_RESET = 2'b01,
        ST_REINT = 2'b10
    } ccs_mode_e;
endpackage

// ### rtl/ccs_ctrl_status.sv
// control, command and status registers of a can protocol controller
// assumes a frame engine on the same clock that pulses its events
import ccs_pkg::*;

// Operation
// - speed select picks resync edge set
// - interrupt request only when matching enable set, wake-up flag always
// - reset request aborts transfers, only cpu clears
// - resume after one or 128 recessive runs
// - config registers reachable only under reset request
// - command write-only, reads ff, blocked in reset
// - passive bits swap pin for reference
// - sleep only when idle and nothing pending
// - sleep during frame gives immediate wake irq
// - after bus wake, receive waits for run
// - release returns receive buffer to device
// - abort cancels queued frame, locked writes dropped
// - transmit request one sends, zero ignored
// - counter 256 sets bus-off and reset request
// - error warning when either counter reaches 96
// - transmitting and receiving status track engine
// - complete status cleared by request, set on success
// - buffer access locked while frame pending
// - overrun when both buffers full, frame dropped
// - receive status reloads from second buffer
// - flags clear together on flag register read
module ccs_ctrl_status (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] cpuAddr,
    input  wire logic       cpuWr,
    input  wire logic       cpuRd,
    input  wire logic [7:0] cpuWdata,
    input  wire logic       txStart,
    input  wire logic       txDone,
    input  wire logic       arbLost,
    input  wire logic       rxStart,
    input  wire logic       frameEnd,
    input  wire logic       rxStore,
    input  wire logic       run11,
    input  wire logic       busIdle,
    input  wire logic [8:0] txErrCnt,
    input  wire logic [8:0] rxErrCnt,
    input  wire logic       wakePin,
    output logic [7:0]      cpuRdata_q,
    output logic            irqReq_q,
    output logic            engineReset_q,
    output logic            bufMapOut_q,
    output logic            resyncBothEdges_q,
    output logic            rxaDisconnect_q,
    output logic            rxbDisconnect_q,
    output logic            comparator_select_q,
    output logic            sleep_q,
    output logic            rxEnable_q,
    output logic            txReqPulse_q,
    output logic            abortPulse_q,
    output logic            clearErrCnt_q,
    output logic            cfgWrEn_q,
    output logic            cfgRdEn_q,
    output logic            txBufWrEn_q
);
    ccs_mode_e  st_q, st_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic       rxa_q, rxa_d, rxb_q, rxb_d, cmp_d, slp_d;
    logic       bs_q, bs_d, es_q, es_d, ts_q, ts_d, rs_q, rs_d;
    logic       tcs_q, tcs_d, tba_q, tba_d, do_q, do_d;
    logic [1:0] rxCnt_q, rxCnt_d;
    logic       pend_q, pend_d, offReq_q, offReq_d, rxEn_d;
    logic [4:0] flg_q, flg_d;
    logic [7:0] rdata_d;
    logic       txReq_d, abort_d, clrErr_d;
    logic       wrCtl, wrCmd, inCfg, inTxb, run, wakeSync, runDone;
    logic [1:0] cnt;

    ccs_pin_sync u_wake (
        .clk       (clk),
        .rst_n     (rst_n),
        .pinIn     (wakePin),
        .pinSync_q (wakeSync)
    );

    ccs_run_counter u_runs (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (st_q != ST_REINT),
        .run11  (run11),
        .target (offReq_q ? RUNS_BUSOFF : RUNS_NORMAL),
        .done   (runDone)
    );

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        st_d = st_q;
        ctrl_d = ctrl_q;
        rxa_d = rxa_q;
        rxb_d = rxb_q;
        cmp_d = comparator_select_q;
        slp_d = sleep_q;
        bs_d = bs_q;
        ts_d = ts_q;
        rs_d = rs_q;
        tcs_d = tcs_q;
        tba_d = tba_q;
        do_d = do_q;
        rxCnt_d = rxCnt_q;
        pend_d = pend_q;
        offReq_d = offReq_q;
        rxEn_d = rxEnable_q;
        txReq_d = 1'b0;
        abort_d = 1'b0;
        clrErr_d = 1'b0;
        cnt = rxCnt_q;
        wrCtl = cpuWr && cpuAddr == OFS_CTRL;
        wrCmd = cpuWr && cpuAddr == OFS_CMD && !ctrl_q[CTL_RR];
        inCfg = inRange(cpuAddr, OFS_CFG_LO, OFS_CFG_HI);
        inTxb = inRange(cpuAddr, OFS_TXB_LO, OFS_TXB_HI);
        run = st_q == ST_RUN;
        // flags clear on read, a set in the same cycle still wins
        flg_d = (cpuRd && cpuAddr == OFS_IFLAG) ? 5'h00 : flg_q;
        es_d = (txErrCnt >= WARN_LIMIT) || (rxErrCnt >= WARN_LIMIT);

        if (wrCtl) begin
            ctrl_d = {cpuWdata[7:6], 1'b0, cpuWdata[4:1], ctrl_q[CTL_RR]};
            if (cpuWdata[CTL_RR]) begin
                ctrl_d[CTL_RR] = 1'b1;
            end else begin
                ctrl_d[CTL_RR] = 1'b0;
            end
        end

        if (wrCmd) begin
            rxa_d = cpuWdata[CMD_RXA];
            rxb_d = cpuWdata[CMD_RXB];
            cmp_d = cpuWdata[CMD_CMP];
            if (cpuWdata[CMD_COS]) begin
                do_d = 1'b0;
            end
            if (cpuWdata[CMD_RRB] && cnt != 2'd0) begin
                cnt = cnt - 2'd1;
            end
            if (cpuWdata[CMD_TR] && tba_q) begin
                tba_d = 1'b0;
                tcs_d = 1'b0;
                pend_d = 1'b1;
                txReq_d = 1'b1;
            end else if (cpuWdata[CMD_AT] && pend_q && !ts_q) begin
                pend_d = 1'b0;
                tba_d = 1'b1;
                abort_d = 1'b1;
                flg_d[IF_TX] = flg_d[IF_TX] | ctrl_q[CTL_TIE];
            end
            if (!cpuWdata[CMD_SLP]) begin
                slp_d = 1'b0;
            end else if (!sleep_q) begin
                if (flg_q == 5'h00 && busIdle && !ts_q && !rs_q) begin
                    slp_d = 1'b1;
                end else begin
                    flg_d[IF_WAKE] = 1'b1;
                end
            end
        end

        if (sleep_q && wakeSync) begin
            slp_d = 1'b0;
            flg_d[IF_WAKE] = 1'b1;
            rxEn_d = 1'b0;
        end else if (run11) begin
            rxEn_d = 1'b1;
        end

        if (run) begin
            if (txStart) begin
                ts_d = 1'b1;
                pend_d = 1'b0;
            end
            if (arbLost) begin
                ts_d = 1'b0;
                rs_d = 1'b1;
                pend_d = 1'b1;
            end
            if (rxStart && !ts_q) begin
                rs_d = 1'b1;
            end
            if (txDone) begin
                ts_d = 1'b0;
                tcs_d = 1'b1;
                tba_d = 1'b1;
                flg_d[IF_TX] = flg_d[IF_TX] | ctrl_q[CTL_TIE];
            end
            if (frameEnd) begin
                ts_d = 1'b0;
                rs_d = 1'b0;
            end
            if (rxStore && rxEnable_q) begin
                if (cnt == 2'd2) begin
                    do_d = 1'b1;
                    flg_d[IF_OVR] = flg_d[IF_OVR] | (ctrl_q[CTL_OIE] & ~do_q);
                end else begin
                    cnt = cnt + 2'd1;
                    flg_d[IF_RX] = flg_d[IF_RX] | ctrl_q[CTL_RIE];
                end
            end
        end
        rxCnt_d = cnt;

        // counters stale while their clear is pending
        if (run && txErrCnt >= BUSOFF_LIMIT && !bs_q && !clearErrCnt_q) begin
            bs_d = 1'b1;
            offReq_d = 1'b1;
            ctrl_d[CTL_RR] = 1'b1;
        end

        case (st_q)
            ST_RUN: begin
                if (ctrl_q[CTL_RR]) begin
                    st_d = ST_RESET;
                end
            end
            ST_RESET: begin
                if (!ctrl_q[CTL_RR]) begin
                    st_d = ST_REINT;
                end
            end
            ST_REINT: begin
                if (ctrl_q[CTL_RR]) begin
                    st_d = ST_RESET;
                end else if (runDone) begin
                    st_d = ST_RUN;
                    if (offReq_q) begin
                        bs_d = 1'b0;
                        offReq_d = 1'b0;
                        clrErr_d = 1'b1;
                    end
                end
            end
            default: st_d = ST_RESET;
        endcase

        if (ctrl_q[CTL_RR]) begin
            // abort transfers, error counters left alone
            ts_d = 1'b0;
            rs_d = 1'b0;
            do_d = 1'b0;
            rxCnt_d = 2'd0;
            tcs_d = 1'b1;
            tba_d = 1'b1;
            pend_d = 1'b0;
            rxa_d = 1'b0;
            rxb_d = 1'b0;
            slp_d = 1'b0;
            flg_d[IF_OVR] = 1'b0;
            flg_d[IF_TX] = 1'b0;
            flg_d[IF_RX] = 1'b0;
        end

        if ((es_d != es_q) || (bs_d != bs_q)) begin
            flg_d[IF_ERR] = flg_d[IF_ERR] | ctrl_q[CTL_EIE];
        end

        rdata_d = 8'h00;
        if (cpuAddr == OFS_CTRL) begin
            rdata_d = ctrl_q;
        end else if (cpuAddr == OFS_CMD) begin
            rdata_d = CMD_READ;
        end else if (cpuAddr == OFS_STAT) begin
            rdata_d = {bs_q, es_q, ts_q, rs_q, tcs_q, tba_q, do_q, rxCnt_q != 2'd0};
        end else if (cpuAddr == OFS_IFLAG) begin
            rdata_d = {3'h0, flg_q};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RESET;
            ctrl_q <= CTRL_RST;
            {bs_q, es_q, ts_q, rs_q, tcs_q, tba_q, do_q} <= STAT_RST[7:1];
            rxCnt_q <= 2'd0;
            pend_q <= 1'b0;
            offReq_q <= 1'b0;
            flg_q <= 5'h00;
            rxa_q <= 1'b0;
            rxb_q <= 1'b0;
            comparator_select_q <= 1'b0;
            sleep_q <= 1'b0;
            rxEnable_q <= 1'b1;
            cpuRdata_q <= 8'h00;
            irqReq_q <= 1'b0;
            engineReset_q <= 1'b1;
            bufMapOut_q <= 1'b0;
            resyncBothEdges_q <= 1'b0;
            rxaDisconnect_q <= 1'b0;
            rxbDisconnect_q <= 1'b0;
            txReqPulse_q <= 1'b0;
            abortPulse_q <= 1'b0;
            clearErrCnt_q <= 1'b0;
            cfgWrEn_q <= 1'b0;
            cfgRdEn_q <= 1'b0;
            txBufWrEn_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            {bs_q, es_q, ts_q, rs_q, tcs_q, tba_q, do_q} <= {bs_d, es_d, ts_d, rs_d,
                                                             tcs_d, tba_d, do_d};
            rxCnt_q <= rxCnt_d;
            pend_q <= pend_d;
            offReq_q <= offReq_d;
            flg_q <= flg_d;
            rxa_q <= rxa_d;
            rxb_q <= rxb_d;
            comparator_select_q <= cmp_d;
            sleep_q <= slp_d;
            rxEnable_q <= rxEn_d;
            if (cpuRd) begin
                cpuRdata_q <= rdata_d;
            end
            irqReq_q <= |flg_d;
            engineReset_q <= st_d != ST_RUN;
            bufMapOut_q <= ctrl_d[CTL_MODE];
            resyncBothEdges_q <= ctrl_d[CTL_SPD];
            rxaDisconnect_q <= rxa_d & ~rxb_d;
            rxbDisconnect_q <= rxb_d & ~rxa_d;
            txReqPulse_q <= txReq_d;
            abortPulse_q <= abort_d;
            clearErrCnt_q <= clrErr_d;
            cfgWrEn_q <= cpuWr && inCfg && ctrl_q[CTL_RR];
            cfgRdEn_q <= cpuRd && inCfg && ctrl_q[CTL_RR];
            txBufWrEn_q <= cpuWr && inTxb && tba_q;
        end
    end
endmodule

// ### rtl/ccs_pin_sync.sv
// three-stage synchroniser for an asynchronous pin
// assumes nothing beyond clk and rst_n; output follows after agreement
module ccs_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      pinSync_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic pinSync_d;

    always_comb begin
        pinSync_d = pinSync_q;
        if (s2_q == s3_q) begin
            pinSync_d = s3_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            pinSync_q <= 1'b0;
        end else begin
            s1_q      <= pinIn;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            pinSync_q <= pinSync_d;
        end
    end
endmodule

// ### rtl/ccs_run_counter.sv
// counts runs of eleven recessive bits up to a target
// assumes run11 is a one-cycle pulse from the frame engine
module ccs_run_counter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       run11,
    input  wire logic [7:0] target,
    output logic            done
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = 8'h00;
        end else if (run11 && cnt_q != target) begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    assign done = !clear && (cnt_q == target);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ### verification/ccs_bus_model.sv
// behavioural frame engine and bus events seen by the status block
// assumes calls just after a rising clock edge
module ccs_bus_model (
    input  wire logic  clk,
    input  wire logic  clearErrCnt_q,
    output logic       txStart,
    output logic       txDone,
    output logic       arbLost,
    output logic       rxStart,
    output logic       frameEnd,
    output logic       rxStore,
    output logic       run11,
    output logic       busIdle,
    output logic [8:0] txErrCnt,
    output logic [8:0] rxErrCnt,
    output logic       wakePin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy = 1'b0;
    assign busIdle = !busy;
    initial begin
        {txStart, txDone, arbLost, rxStart, frameEnd, rxStore, run11} = 7'h00;
        txErrCnt = 9'h000;
        rxErrCnt = 9'h000;
        wakePin = 1'b0;
    end
    // counters cleared on request after bus-off
    always @(posedge clk) begin
        if (clearErrCnt_q) begin
            txErrCnt <= 9'h000;
            rxErrCnt <= 9'h000;
        end
    end
    task automatic ev(input logic [6:0] e);
        @(posedge clk);
        #2;
        {txStart, txDone, arbLost, rxStart, frameEnd, rxStore, run11} = e;
        if (e[6] || e[3]) busy = 1'b1;
        @(posedge clk);
        #2;
        {txStart, txDone, arbLost, rxStart, frameEnd, rxStore, run11} = 7'h00;
        if (e[2]) busy = 1'b0;
    endtask
    task automatic cnt(input logic [8:0] t, input logic [8:0] r);
        @(posedge clk);
        #2;
        txErrCnt = t;
        rxErrCnt = r;
    endtask
    task automatic wake();
        @(posedge clk);
        #2;
        wakePin = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        wakePin = 1'b0;
    endtask
endmodule

// ### verification/ccs_ctrl_status_properties.sv
// checker for the register port of the control and status block
// assumes binding to ccs_ctrl_status, one clock domain
module ccs_ctrl_status_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] cpuAddr,
    input wire logic       cpuWr,
    input wire logic       cpuRd,
    input wire logic [7:0] cpuWdata,
    input wire logic       run11,
    input wire logic       busIdle,
    input wire logic [7:0] cpuRdata_q,
    input wire logic       engineReset_q,
    input wire logic       resyncBothEdges_q,
    input wire logic       rxaDisconnect_q,
    input wire logic       sleep_q,
    input wire logic       txReqPulse_q,
    input wire logic       cfgWrEn_q
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cmdWr;
    logic ctlWr;
    assign cmdWr = cpuWr && cpuAddr == OFS_CMD;
    assign ctlWr = cpuWr && cpuAddr == OFS_CTRL;
    property p_cmdRead; cpuRd && cpuAddr == OFS_CMD |=> cpuRdata_q == CMD_READ; endproperty
    a_cmdRead: assert property (p_cmdRead) else $error("command read not all ones");
    property p_txZero; cmdWr && !cpuWdata[CMD_TR] |=> !txReqPulse_q; endproperty
    a_txZero: assert property (p_txZero) else $error("zero request sent a frame");
    property p_rrSet; ctlWr && cpuWdata[CTL_RR] |=> ##1 engineReset_q; endproperty
    a_rrSet: assert property (p_rrSet) else $error("reset request not taken");
    property p_reint; $fell(engineReset_q) |-> $past(run11) || $past(run11, 2); endproperty
    a_reint: assert property (p_reint) else $error("resumed without recessive run");
    property p_spd; ctlWr |=> resyncBothEdges_q == $past(cpuWdata[CTL_SPD]); endproperty
    a_spd: assert property (p_spd) else $error("resync edge choice wrong");
    property p_passive;
        cmdWr && !engineReset_q |=>
            rxaDisconnect_q == ($past(cpuWdata[CMD_RXA]) && !$past(cpuWdata[CMD_RXB]));
    endproperty
    a_passive: assert property (p_passive) else $error("pin a disconnect wrong");
    property p_cfgGate;
        cpuWr && cpuAddr inside {[OFS_CFG_LO:OFS_CFG_HI]} && !engineReset_q |=> !cfgWrEn_q;
    endproperty
    a_cfgGate: assert property (p_cfgGate) else $error("config written while running");
    property p_sleepBusy; cmdWr && cpuWdata[CMD_SLP] && !busIdle |=> !sleep_q; endproperty
    a_sleepBusy: assert property (p_sleepBusy) else $error("slept on a busy bus");
    c_txReq: cover property (txReqPulse_q);
    c_sleep: cover property (sleep_q);
    c_cfgWr: cover property (cfgWrEn_q);
endmodule

bind ccs_ctrl_status ccs_ctrl_status_chk ccs_ctrl_status_chk_inst (
    .clk, .rst_n, .cpuAddr, .cpuWr, .cpuRd, .cpuWdata, .run11, .busIdle, .cpuRdata_q,
    .engineReset_q, .resyncBothEdges_q, .rxaDisconnect_q, .sleep_q, .txReqPulse_q, .cfgWrEn_q
);

// ### verification/ccs_ctrl_status_tb_top.sv
// self-checking bench for the can control, command and status block
// assumes ccs_bus_model as far side and the bound checker
module ccs_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic [7:0] cpuAddr  = 8'h00;
    logic [7:0] cpuWdata = 8'h00;
    logic       cpuWr    = 1'b0;
    logic       cpuRd    = 1'b0;
    logic       txStart, txDone, arbLost, rxStart, frameEnd, rxStore, run11, busIdle, wakePin;
    logic [8:0] txErrCnt, rxErrCnt;
    logic [7:0] cpuRdata_q;
    logic       irqReq_q, engineReset_q, bufMapOut_q, resyncBothEdges_q, rxaDisconnect_q;
    logic       rxbDisconnect_q, comparator_select_q, sleep_q, rxEnable_q, txReqPulse_q, abortPulse_q;
    logic       clearErrCnt_q, cfgWrEn_q, cfgRdEn_q, txBufWrEn_q;
    int         err_total       = 0;
    int         samples_checked = 0;
    localparam logic [6:0] TXS = 7'h40, TXD = 7'h20, RXS = 7'h08, FEND = 7'h04, STO = 7'h02;
    ccs_ctrl_status ccs_ctrl_status_inst (
        .clk, .rst_n, .cpuAddr, .cpuWr, .cpuRd, .cpuWdata, .txStart, .txDone, .arbLost,
        .rxStart, .frameEnd, .rxStore, .run11, .busIdle, .txErrCnt, .rxErrCnt, .wakePin,
        .cpuRdata_q, .irqReq_q, .engineReset_q, .bufMapOut_q, .resyncBothEdges_q,
        .rxaDisconnect_q, .rxbDisconnect_q, .comparator_select_q, .sleep_q, .rxEnable_q, .txReqPulse_q,
        .abortPulse_q, .clearErrCnt_q, .cfgWrEn_q, .cfgRdEn_q, .txBufWrEn_q
    );
    ccs_bus_model ccs_bus_model_inst (
        .clk, .clearErrCnt_q, .txStart, .txDone, .arbLost, .rxStart, .frameEnd, .rxStore,
        .run11, .busIdle, .txErrCnt, .rxErrCnt, .wakePin
    );
    always #12.5 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chb(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        cpuAddr = a;
        cpuWdata = d;
        cpuWr = 1'b1;
        @(posedge clk);
        #2;
        cpuWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        #2;
        cpuAddr = a;
        cpuRd = 1'b1;
        @(posedge clk);
        #2;
        cpuRd = 1'b0;
        samples_checked++;
        if (cpuRdata_q !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, cpuRdata_q);
        end
    endtask
    task automatic ev(input logic [6:0] e);
        ccs_bus_model_inst.ev(e);
    endtask
    task automatic runs(input int n);
        repeat (n) ccs_bus_model_inst.ev(7'h01);
    endtask
    task automatic s_reset();
        rd(OFS_CTRL, CTRL_RST, "ctrl");
        rd(OFS_STAT, STAT_RST, "stat");
        rd(OFS_CMD, CMD_READ, "cmd");
        rd(8'h3F, 8'h00, "unmapped");
        chb("mapout", 1'b0, bufMapOut_q);
    endtask
    task automatic s_start();
        wr(OFS_CMD, 8'h01);
        chb("txreq", 1'b0, txReqPulse_q);
        wr(OFS_CFG_LO, 8'h55);
        chb("cfgwr", 1'b1, cfgWrEn_q);
        rd(OFS_CFG_LO, 8'h00, "cfgdata");
        chb("cfgrd", 1'b1, cfgRdEn_q);
        wr(OFS_CTRL, 8'h5E);
        chb("resync", 1'b1, resyncBothEdges_q);
        chb("reint", 1'b1, engineReset_q);
        runs(1);
        rd(OFS_CTRL, 8'h5E, "ctrl");
        chb("run", 1'b0, engineReset_q);
        wr(OFS_CFG_LO, 8'h55);
        chb("cfgwr", 1'b0, cfgWrEn_q);
        rd(OFS_CFG_LO, 8'h00, "cfgdata");
        chb("cfgrd", 1'b0, cfgRdEn_q);
    endtask
    task automatic s_tx();
        wr(OFS_CMD, 8'h01);
        chb("txreq", 1'b1, txReqPulse_q);
        rd(OFS_STAT, 8'h00, "stat");
        wr(OFS_TXB_LO, 8'hA5);
        chb("txbuf", 1'b0, txBufWrEn_q);
        wr(OFS_CMD, 8'h00);
        ev(TXS);
        rd(OFS_STAT, 8'h20, "stat");
        ev(TXD | FEND);
        rd(OFS_STAT, 8'h0C, "stat");
        chb("irq", 1'b1, irqReq_q);
        rd(OFS_IFLAG, 8'h02, "iflag");
        wr(OFS_TXB_LO, 8'hA5);
        chb("txbuf", 1'b1, txBufWrEn_q);
        chb("irq", 1'b0, irqReq_q);
    endtask
    task automatic s_abort();
        wr(OFS_CMD, 8'h01);
        wr(OFS_CMD, 8'h02);
        chb("abort", 1'b1, abortPulse_q);
        rd(OFS_STAT, 8'h04, "stat");
        chb("irq", 1'b1, irqReq_q);
        wr(OFS_CTRL, 8'h5F);
        rd(OFS_IFLAG, 8'h00, "iflag");
        chb("rr", 1'b1, engineReset_q);
        wr(OFS_CTRL, 8'h5E);
        runs(1);
        rd(OFS_CTRL, 8'h5E, "ctrl");
        chb("run", 1'b0, engineReset_q);
    endtask
    task automatic s_rx();
        repeat (3) ev(STO);
        rd(OFS_STAT, 8'h0F, "stat");
        wr(OFS_CMD, 8'h04);
        rd(OFS_STAT, 8'h0F, "stat");
        wr(OFS_CMD, 8'h04);
        rd(OFS_STAT, 8'h0E, "stat");
        wr(OFS_CMD, 8'h08);
        rd(OFS_STAT, 8'h0C, "stat");
        rd(OFS_IFLAG, 8'h09, "iflag");
    endtask
    task automatic s_err();
        ccs_bus_model_inst.cnt(9'h060, 9'h000);
        rd(OFS_STAT, 8'h4C, "stat");
        rd(OFS_IFLAG, 8'h04, "iflag");
        ccs_bus_model_inst.cnt(9'h05F, 9'h060);
        rd(OFS_STAT, 8'h4C, "stat");
        ccs_bus_model_inst.cnt(9'h100, 9'h060);
        rd(OFS_STAT, 8'hCC, "stat");
        rd(OFS_CTRL, 8'h5F, "ctrl");
        wr(OFS_CTRL, 8'h5E);
        runs(127);
        chb("busoff", 1'b1, engineReset_q);
        runs(1);
        @(posedge clk);
        #2;
        chb("clrerr", 1'b1, clearErrCnt_q);
        rd(OFS_CTRL, 8'h5E, "ctrl");
        rd(OFS_CMD, CMD_READ, "cmd");
        rd(OFS_STAT, 8'h0C, "stat");
        rd(OFS_IFLAG, 8'h04, "iflag");
    endtask
    task automatic s_sleep();
        ev(RXS);
        rd(OFS_STAT, 8'h1C, "stat");
        wr(OFS_CMD, 8'h10);
        chb("sleep", 1'b0, sleep_q);
        rd(OFS_IFLAG, 8'h10, "iflag");
        ev(FEND);
        rd(OFS_STAT, 8'h0C, "stat");
        wr(OFS_CMD, 8'h10);
        chb("sleep", 1'b1, sleep_q);
        ccs_bus_model_inst.wake();
        chb("sleep", 1'b0, sleep_q);
        chb("rxen", 1'b0, rxEnable_q);
        ev(STO);
        rd(OFS_STAT, 8'h0C, "stat");
        runs(1);
        chb("rxen", 1'b1, rxEnable_q);
        rd(OFS_IFLAG, 8'h10, "iflag");
        wr(OFS_CMD, 8'h10);
        wr(OFS_CMD, 8'hA0);
        chb("sleep", 1'b0, sleep_q);
        chb("rxa", 1'b1, rxaDisconnect_q);
        chb("cmp", 1'b1, comparator_select_q);
        wr(OFS_CMD, 8'hC0);
        chb("rxa", 1'b0, rxaDisconnect_q);
        chb("rxb", 1'b0, rxbDisconnect_q);
        rd(OFS_IFLAG, 8'h00, "iflag");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #2;
        rst_n = 1'b1;
        s_reset();
        s_start();
        s_tx();
        s_abort();
        s_rx();
        s_err();
        s_sleep();
        test_done();
    end
    // about 400 cycles expected, limit fifty times that
    initial begin
        #500000;
        err_total++;
        test_done();
    end
endmodule
